// *** src/onchip_flash_command_engine.sv ***
`timescale 1ns/1ps
module onchip_flash_command_engine #(
  parameter int MAX_RETRY = 4,
  parameter logic [15:0] ALG_REVISION = 16'h0100, // arbitrary value
  parameter logic [15:0] CIRCUIT_ID_LO = 16'h1234, // arbitrary value
  parameter logic [15:0] CIRCUIT_ID_HI = 16'h5678 // arbitrary value
) (
  input wire logic clk, // 50 mhz system clock
  input wire logic sys_rst, // synchronous reset, active high
  input wire logic cmd_valid, // command request
  input wire flash_engine_pkg::cmd_req_t cmd_req, // working registers in
  input wire flash_engine_pkg::cpu_env_t cpu_env, // stack, period, clock health
  input wire logic protect_enable, // read-back protection option
  input wire logic vpp_present_pin, // programming supply sense pin
  input wire logic init_phase, // high until end of initialization
  input wire logic map_segment1, // 1 maps low banks to segment 1
  input wire logic fetch_req, // read request
  input wire logic [19:0] fetch_addr, // cpu byte address
  input wire logic [1:0] fetch_origin, // where the reading code runs
  output logic cmd_ready_q, // engine idle
  output logic cmd_done_q, // one-cycle completion pulse
  output flash_engine_pkg::cmd_rsp_t rsp_q, // working registers out
  output logic fetch_ready_q, // fetch can be accepted this cycle
  output logic fetch_valid_q, // fetch data valid
  output logic fetch_blocked_q, // fetch refused by protection
  output logic fetch_fault_q, // fetch outside the flash map
  output logic [31:0] fetch_data_q // 32-bit fetch data
);

  initial
  begin
    if (MAX_RETRY < 1 || MAX_RETRY > 15)
      $error("onchip_flash_command_engine: MAX_RETRY out of range");
  end

  typedef enum logic [14:0] {
    ST_IDLE = 15'h0001,
    ST_CHECK = 15'h0002,
    ST_SRC_RD = 15'h0004,
    ST_SRC_GET = 15'h0008,
    ST_DST_RD = 15'h0010,
    ST_DST_WR = 15'h0020,
    ST_VER_RD = 15'h0040,
    ST_VER_CHK = 15'h0080,
    ST_ERA_WR = 15'h0100,
    ST_ERA_RD = 15'h0200,
    ST_ERA_CHK = 15'h0400,
    ST_RB_RD = 15'h0800,
    ST_RB_LO = 15'h1000,
    ST_RB_HI = 15'h2000,
    ST_DONE = 15'h4000
  } state_t;

  localparam logic [3:0] RETRY_LAST = 4'(MAX_RETRY - 1);

  // {valid, array byte address}; gap in segment 0 is unmapped
  function automatic logic [18:0] map_addr(input logic [19:0] a, input logic seg1);
    logic [19:0] rel;
    rel = a - flash_engine_pkg::MAP_SHIFT;
    if (!seg1 && a < flash_engine_pkg::SEG0_LOW_END)
      return {1'b1, a[17:0]};
    else if (!seg1 && a >= flash_engine_pkg::SEG0_HIGH_BASE && a < flash_engine_pkg::FLASH_END)
      return {1'b1, rel[17:0]};
    else if (seg1 && a >= flash_engine_pkg::SEG1_BASE && a < flash_engine_pkg::FLASH_END)
      return {1'b1, rel[17:0]};
    else
      return 19'h00000;
  endfunction : map_addr

  // anything outside the defined set becomes the unknown code
  function automatic logic [7:0] legal_code(input logic [7:0] c);
    if (c <= flash_engine_pkg::ERR_ERASE_PH2)
      return c;
    else
      return flash_engine_pkg::ERR_UNKNOWN;
  endfunction : legal_code

  state_t state_q, state_d;
  flash_engine_pkg::cmd_req_t req_q;
  logic [7:0] err_q;
  logic [17:0] dst_q;
  logic [17:0] src_q;
  logic [15:0] off_q;
  logic [15:0] left_q;
  logic [15:0] wdata_q;
  logic [3:0] retry_q;
  logic [15:0] idx_q;
  logic [1:0] bank_q;
  logic phase_q;
  logic [15:0] rb_lo_q;
  logic [15:0] rb_hi_q;
  logic map_seg1_q;
  logic vpp_meta_q, vpp_q;
  logic [31:0] rdata;

  // supply sense comes from a pin: two flops before use
  always_ff @(posedge clk)
  begin
    vpp_meta_q <= vpp_present_pin;
    vpp_q <= vpp_meta_q;
  end

  // mapping follows its input only while initialization is open
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      map_seg1_q <= 1'b0;
    else if (init_phase)
      map_seg1_q <= map_segment1;
  end

  // parameter decode for the command in flight
  wire is_single = req_q.cmd == flash_engine_pkg::CMD_PROG_SINGLE;
  wire is_double = req_q.cmd == flash_engine_pkg::CMD_PROG_DOUBLE;
  wire is_block = req_q.cmd == flash_engine_pkg::CMD_PROG_BLOCK;
  wire is_erase = req_q.cmd == flash_engine_pkg::CMD_ERASE;
  wire is_status = req_q.cmd == flash_engine_pkg::CMD_STATUS;
  wire is_prog = is_single || is_double || is_block;
  wire [19:0] dst_cpu = {req_q.seg, req_q.offset};
  wire [19:0] src_cpu = {req_q.data_hi[3:0], req_q.data_lo};
  wire [15:0] words = is_block ? req_q.count : (is_double ? 16'h0002 : 16'h0001);
  wire [19:0] span = {3'h0, words, 1'b0} - 20'h00002;
  wire [18:0] dst_map = map_addr(dst_cpu, map_seg1_q);
  wire [18:0] dst_end_map = map_addr(dst_cpu + span, map_seg1_q);
  wire [18:0] src_map = map_addr(src_cpu, map_seg1_q);
  wire [18:0] src_end_map = map_addr(src_cpu + span, map_seg1_q);
  wire dst_ok = dst_map[18] && !dst_cpu[0];
  // the end must map and be contiguous, so crossing the gap is refused too
  wire dst_end_ok = dst_end_map[18] && (dst_end_map[17:0] - dst_map[17:0]) == span[17:0];
  wire src_ok = src_map[18] && !src_cpu[0] && src_end_map[18]
    && (src_end_map[17:0] - src_map[17:0]) == span[17:0];
  wire [15:0] stack_gap = cpu_env.stack_pointer - cpu_env.stack_overflow_limit;
  wire stack_ok = cpu_env.stack_pointer >= cpu_env.stack_overflow_limit
    && {1'b0, stack_gap[15:1]} >= flash_engine_pkg::STACK_MIN_WORDS;
  wire period_ok = cpu_env.cpu_period_ns >= flash_engine_pkg::PERIOD_MIN_NS
    && cpu_env.cpu_period_ns <= flash_engine_pkg::PERIOD_MAX_NS;
  wire clock_bad = !cpu_env.pll_locked || cpu_env.osc_wdt_overflow;

  // common checks first, then the command-specific ones
  wire [7:0] check_code =
    !(is_prog || is_erase || is_status) ? flash_engine_pkg::ERR_UNKNOWN :
    is_status ? flash_engine_pkg::ERR_OK :
    !period_ok ? flash_engine_pkg::ERR_PERIOD :
    !stack_ok ? flash_engine_pkg::ERR_STACK :
    protect_enable ? flash_engine_pkg::ERR_PROTECT :
    !vpp_q ? flash_engine_pkg::ERR_NO_VPP :
    is_erase ? (req_q.data_lo > 16'h0003 ? flash_engine_pkg::ERR_BANK
                                         : flash_engine_pkg::ERR_OK) :
    !dst_ok ? flash_engine_pkg::ERR_BAD_ADDR :
    (is_block && words != 16'h0000 && !src_ok) ? flash_engine_pkg::ERR_BAD_SRC :
    (words == 16'h0000 || !dst_end_ok) ? flash_engine_pkg::ERR_BAD_COUNT :
    flash_engine_pkg::ERR_OK;

  // the half-word selected by an array byte address
  wire [15:0] dst_half = dst_q[1] ? rdata[31:16] : rdata[15:0];
  wire [15:0] src_half = src_q[1] ? rdata[31:16] : rdata[15:0];
  wire [17:0] dst_next = dst_q + 18'h00002;
  // readback starts from the original target: the walk has moved on by then
  wire [17:0] rb_next = dst_map[17:0] + 18'h00002;
  wire [31:0] erase_word = phase_q ? 32'hffffffff : 32'h00000000;
  wire era_last = idx_q == flash_engine_pkg::BANK_LAST[bank_q];
  wire last_word = left_q == 16'h0001;
  wire can_retry = retry_q < RETRY_LAST;
  wire busy_op = !(state_q == ST_IDLE || state_q == ST_CHECK || state_q == ST_DONE
    || state_q == ST_RB_RD || state_q == ST_RB_LO || state_q == ST_RB_HI);
  wire abort = busy_op && clock_bad;

  // fetch path uses the single array port only while idle
  wire [18:0] fetch_map = map_addr(fetch_addr, map_seg1_q);
  wire fetch_take = fetch_req && state_q == ST_IDLE;
  wire fetch_prot = protect_enable && fetch_origin != flash_engine_pkg::ORIGIN_FLASH;
  wire fetch_bad = !fetch_map[18];

  // array port selection
  wire [15:0] mem_addr =
    (state_q == ST_IDLE) ? fetch_map[17:2] :
    (state_q == ST_SRC_RD) ? src_q[17:2] :
    (state_q == ST_RB_RD) ? dst_map[17:2] :
    (state_q == ST_RB_LO) ? rb_next[17:2] :
    (state_q == ST_ERA_WR || state_q == ST_ERA_RD) ? idx_q :
    dst_q[17:2];
  wire mem_we = (state_q == ST_DST_WR || state_q == ST_ERA_WR) && !clock_bad;
  wire [1:0] mem_half = (state_q == ST_ERA_WR) ? 2'b11 : (dst_q[1] ? 2'b10 : 2'b01);
  // program can only clear bits: old contents and new data are combined
  wire [15:0] prog_half = dst_half & wdata_q;
  wire [31:0] mem_wdata = (state_q == ST_ERA_WR) ? erase_word : {prog_half, prog_half};
  wire mem_blank = (state_q == ST_IDLE) && (fetch_prot || fetch_bad);

  flash_array #(
    .DATA_W(32),
    .DEPTH(65536),
    .AW(16)
  ) u_array (
    .clk(clk),
    .addr(mem_addr),
    .we(mem_we),
    .half_en(mem_half),
    .wdata(mem_wdata),
    .rd_blank(mem_blank),
    .rdata_q(rdata)
  );
  assign fetch_data_q = rdata;

  // sequencer next state
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: if (cmd_valid) state_d = ST_CHECK;
      ST_CHECK:
        if (check_code != flash_engine_pkg::ERR_OK || is_status) state_d = ST_DONE;
        else if (is_erase) state_d = ST_ERA_WR;
        else if (is_block) state_d = ST_SRC_RD;
        else state_d = ST_DST_RD;
      ST_SRC_RD: state_d = ST_SRC_GET;
      ST_SRC_GET: state_d = ST_DST_RD;
      ST_DST_RD: state_d = ST_DST_WR;
      ST_DST_WR: state_d = ST_VER_RD;
      ST_VER_RD: state_d = ST_VER_CHK;
      ST_VER_CHK:
        if (dst_half == wdata_q && !last_word) state_d = is_block ? ST_SRC_RD : ST_DST_RD;
        else if (dst_half != wdata_q && can_retry) state_d = ST_DST_RD;
        else state_d = is_block ? ST_DONE : ST_RB_RD;
      ST_ERA_WR: state_d = ST_ERA_RD;
      ST_ERA_RD: state_d = ST_ERA_CHK;
      ST_ERA_CHK:
        if (rdata != erase_word) state_d = can_retry ? ST_ERA_WR : ST_DONE;
        else if (era_last && phase_q) state_d = ST_DONE;
        else state_d = ST_ERA_WR;
      ST_RB_RD: state_d = ST_RB_LO;
      ST_RB_LO: state_d = ST_RB_HI;
      ST_RB_HI: state_d = ST_DONE;
      ST_DONE: state_d = ST_IDLE;
      default: state_d = ST_IDLE;
    endcase
    if (abort)
      state_d = ST_DONE;
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      state_q <= ST_IDLE;
    else
      state_q <= state_d;
  end

  // command capture and error code
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      req_q <= '0;
      err_q <= flash_engine_pkg::ERR_OK;
    end
    else if (state_q == ST_IDLE && cmd_valid)
    begin
      req_q <= cmd_req;
      err_q <= flash_engine_pkg::ERR_OK;
    end
    else if (abort)
      err_q <= flash_engine_pkg::ERR_CLOCK;
    else if (state_q == ST_CHECK)
      err_q <= check_code;
    else if (state_q == ST_VER_CHK && dst_half != wdata_q && !can_retry)
      err_q <= flash_engine_pkg::ERR_PROG_FAIL;
    else if (state_q == ST_ERA_CHK && rdata != erase_word && !can_retry)
      err_q <= phase_q ? flash_engine_pkg::ERR_ERASE_PH2 : flash_engine_pkg::ERR_ERASE_PH1;
  end

  // program walk: destination, source, data and words left
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      dst_q <= '0;
      src_q <= '0;
      off_q <= '0;
      left_q <= '0;
      wdata_q <= '0;
    end
    else if (state_q == ST_CHECK)
    begin
      dst_q <= dst_map[17:0];
      src_q <= src_map[17:0];
      off_q <= req_q.offset;
      left_q <= words;
      wdata_q <= req_q.data_lo;
    end
    else if (state_q == ST_SRC_GET)
      wdata_q <= src_half;
    else if (state_q == ST_VER_CHK && dst_half == wdata_q && !last_word)
    begin
      // offset stays on the failing or last word for block reporting
      dst_q <= dst_next;
      src_q <= src_q + 18'h00002;
      off_q <= off_q + 16'h0002;
      left_q <= left_q - 16'h0001;
      wdata_q <= req_q.data_hi;
    end
  end

  // retry counter restarts on every new word or entry
  always_ff @(posedge clk)
  begin
    if (sys_rst || state_q == ST_CHECK)
      retry_q <= '0;
    else if (state_q == ST_VER_CHK)
      retry_q <= (dst_half == wdata_q) ? 4'h0 : retry_q + 4'h1;
    else if (state_q == ST_ERA_CHK)
      retry_q <= (rdata == erase_word) ? 4'h0 : retry_q + 4'h1;
  end

  // erase walk: phase 1 clears every entry, phase 2 sets it
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      idx_q <= '0;
      bank_q <= '0;
      phase_q <= 1'b0;
    end
    else if (state_q == ST_CHECK)
    begin
      bank_q <= req_q.data_lo[1:0];
      idx_q <= flash_engine_pkg::BANK_FIRST[req_q.data_lo[1:0]];
      phase_q <= 1'b0;
    end
    else if (state_q == ST_ERA_CHK && rdata == erase_word)
    begin
      if (era_last)
      begin
        idx_q <= flash_engine_pkg::BANK_FIRST[bank_q];
        phase_q <= 1'b1;
      end
      else
        idx_q <= idx_q + 16'h0001;
    end
  end

  // read back the target word and the next one after word programming
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      rb_lo_q <= '0;
      rb_hi_q <= '0;
    end
    else if (state_q == ST_RB_LO)
      rb_lo_q <= dst_map[1] ? rdata[31:16] : rdata[15:0];
    else if (state_q == ST_RB_HI)
      rb_hi_q <= rb_next[1] ? rdata[31:16] : rdata[15:0];
  end

  // return values; registers beyond these are never touched
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      rsp_q <= '0;
    else if (state_q == ST_DONE)
    begin
      rsp_q.result_word <= {8'h00, legal_code(err_q)};
      rsp_q.target_offset_word <= is_status ? ALG_REVISION :
        (is_block ? off_q : req_q.offset);
      rsp_q.data_low_word <= is_status ? CIRCUIT_ID_LO :
        ((is_single || is_double) ? rb_lo_q : req_q.data_lo);
      rsp_q.data_high_word <= is_status ? CIRCUIT_ID_HI :
        ((is_single || is_double) ? rb_hi_q : req_q.data_hi);
      rsp_q.multiply_divide_high <= idx_q;
      rsp_q.multiply_divide_low <= left_q;
      rsp_q.multiply_divide_ctrl <= {11'h000, phase_q, retry_q};
    end
  end

  // handshake and fetch status flags
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      cmd_ready_q <= 1'b0;
      cmd_done_q <= 1'b0;
      fetch_ready_q <= 1'b0;
      fetch_valid_q <= 1'b0;
      fetch_blocked_q <= 1'b0;
      fetch_fault_q <= 1'b0;
    end
    else
    begin
      cmd_ready_q <= state_d == ST_IDLE;
      cmd_done_q <= state_q == ST_DONE;
      fetch_ready_q <= state_d == ST_IDLE;
      fetch_valid_q <= fetch_take;
      fetch_blocked_q <= fetch_take && fetch_prot;
      fetch_fault_q <= fetch_take && fetch_bad;
    end
  end

endmodule : onchip_flash_command_engine

// *** src/flash_engine_pkg.sv ***
package flash_engine_pkg;

  // address widths: segment nibble plus 16-bit offset, 256k byte array
  localparam int ADDR_W = 20;
  localparam int ARR_W = 18;
  localparam int IDX_W = 16;

  // error codes returned in the result word
  localparam logic [7:0] ERR_OK = 8'h00;
  localparam logic [7:0] ERR_PROTECT = 8'h01;
  localparam logic [7:0] ERR_NO_VPP = 8'h02;
  localparam logic [7:0] ERR_PROG_FAIL = 8'h03;
  localparam logic [7:0] ERR_BAD_ADDR = 8'h04;
  localparam logic [7:0] ERR_PERIOD = 8'h05;
  localparam logic [7:0] ERR_STACK = 8'h06;
  localparam logic [7:0] ERR_BANK = 8'h07;
  localparam logic [7:0] ERR_ERASE_PH1 = 8'h08;
  localparam logic [7:0] ERR_BAD_SRC = 8'h09;
  localparam logic [7:0] ERR_BAD_COUNT = 8'h0a;
  localparam logic [7:0] ERR_CLOCK = 8'h0b;
  localparam logic [7:0] ERR_ERASE_PH2 = 8'h0c;
  localparam logic [7:0] ERR_UNKNOWN = 8'hff;

  // command codes
  localparam logic [7:0] CMD_PROG_SINGLE = 8'h01;
  localparam logic [7:0] CMD_PROG_DOUBLE = 8'h02;
  localparam logic [7:0] CMD_PROG_BLOCK = 8'h03;
  localparam logic [7:0] CMD_ERASE = 8'h04;
  localparam logic [7:0] CMD_STATUS = 8'h05;

  // address map boundaries (cpu byte addresses)
  localparam logic [19:0] SEG0_LOW_END = 20'h08000;
  localparam logic [19:0] SEG0_HIGH_BASE = 20'h18000;
  localparam logic [19:0] SEG1_BASE = 20'h10000;
  localparam logic [19:0] MAP_SHIFT = 20'h10000;
  localparam logic [19:0] FLASH_END = 20'h50000;

  // bank bounds as 32-bit word indices: 16k, 48k, 96k, 96k
  localparam logic [15:0] BANK_FIRST [4] = '{16'h0000, 16'h1000, 16'h4000, 16'ha000};
  localparam logic [15:0] BANK_LAST [4] = '{16'h0fff, 16'h3fff, 16'h9fff, 16'hffff};

  // parameter checks
  localparam logic [15:0] STACK_MIN_WORDS = 16'h0032;
  localparam logic [15:0] PERIOD_MIN_NS = 16'h001e;
  localparam logic [15:0] PERIOD_MAX_NS = 16'h01f4;

  // fetch origins
  localparam logic [1:0] ORIGIN_FLASH = 2'h0;

  // a command as handed over in the working registers
  typedef struct packed {
    logic [7:0] cmd;
    logic [3:0] seg;
    logic [15:0] offset;
    logic [15:0] data_lo;
    logic [15:0] data_hi;
    logic [15:0] count;
  } cmd_req_t;

  // cpu environment seen during a command
  typedef struct packed {
    logic [15:0] stack_pointer;
    logic [15:0] stack_overflow_limit;
    logic [15:0] cpu_period_ns;
    logic pll_locked;
    logic osc_wdt_overflow;
  } cpu_env_t;

  // values returned in the working registers
  typedef struct packed {
    logic [15:0] result_word;
    logic [15:0] target_offset_word;
    logic [15:0] data_low_word;
    logic [15:0] data_high_word;
    logic [15:0] multiply_divide_high;
    logic [15:0] multiply_divide_low;
    logic [15:0] multiply_divide_ctrl;
  } cmd_rsp_t;

endpackage : flash_engine_pkg

// *** src/flash_array.sv ***
`timescale 1ns/1ps
module flash_array #(
  parameter int DATA_W = 32,
  parameter int DEPTH = 65536,
  parameter int AW = 16
) (
  input wire logic clk, // system clock
  input wire logic [AW-1:0] addr, // word index
  input wire logic we, // write strobe
  input wire logic [1:0] half_en, // half-word lanes written
  input wire logic [DATA_W-1:0] wdata, // write data
  input wire logic rd_blank, // return zeros instead of contents
  output logic [DATA_W-1:0] rdata_q // registered read data
);

  localparam int HALF_W = DATA_W / 2;

  initial
  begin
    if (DATA_W % 2 != 0 || DEPTH > (1 << AW) || DEPTH < 1)
      $error("flash_array: unsupported geometry");
  end

  logic [DATA_W-1:0] mem [DEPTH];

  // one lane per half-word so single words program on their own
  for (genvar h = 0; h < 2; h++)
  begin : g_lane
    always_ff @(posedge clk)
    begin
      if (we && half_en[h])
        mem[addr][h*HALF_W +: HALF_W] <= wdata[h*HALF_W +: HALF_W];
    end
  end

  // blanking at the read register keeps protected data off the fetch path only while idle; engine reads are not blanked
  always_ff @(posedge clk)
  begin
    rdata_q <= rd_blank ? '0 : mem[addr];
  end

endmodule : flash_array

// *** sim/flash_engine_props.sv ***
`timescale 1ns/1ps
module flash_engine_props (
  input wire logic clk, // clock
  input wire logic sys_rst, // reset
  input wire logic cmd_valid, // request
  input wire flash_engine_pkg::cmd_req_t cmd_req, // command
  input wire flash_engine_pkg::cpu_env_t cpu_env, // environment
  input wire logic protect_enable, // protection
  input wire logic fetch_req, // fetch request
  input wire logic [19:0] fetch_addr, // fetch address
  input wire logic [1:0] fetch_origin, // fetch origin
  input wire logic cmd_ready_q, // idle
  input wire logic cmd_done_q, // done pulse
  input wire flash_engine_pkg::cmd_rsp_t rsp_q, // results
  input wire logic fetch_ready_q, // fetch idle
  input wire logic fetch_valid_q, // fetch valid
  input wire logic fetch_blocked_q, // fetch blocked
  input wire logic fetch_fault_q, // fetch fault
  input wire logic [31:0] fetch_data_q // fetch data
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // accepted requests and the returned code
  wire take = cmd_valid && cmd_ready_q;
  wire ftake = fetch_req && fetch_ready_q;
  wire [7:0] code = rsp_q.result_word[7:0];

  a_done_pulse: assert property (cmd_done_q |=> !cmd_done_q)
    else $error("done pulse longer than one cycle");
  a_busy_take: assert property (take |=> !cmd_ready_q)
    else $error("engine still idle after a take");
  a_status_fast: assert property (take && cmd_req.cmd == 8'h05 |-> ##[2:3] cmd_done_q)
    else $error("status read not answered in time");
  a_period_code: assert property (take && cmd_req.cmd inside {[8'h01:8'h04]}
    && cpu_env.cpu_period_ns < 16'h001e |-> ##[2:3] (cmd_done_q && code == 8'h05))
    else $error("short period not reported");
  a_unknown_code: assert property (take && cmd_req.cmd inside {8'h00, [8'h06:8'hff]}
    |-> ##[2:3] (cmd_done_q && code == 8'hff))
    else $error("unknown command not reported");
  a_code_legal: assert property (cmd_done_q |-> rsp_q.result_word[15:8] == 8'h00
    && (code <= 8'h0c || code == 8'hff))
    else $error("undefined result code");
  a_rsp_hold: assert property (!cmd_done_q && !$past(sys_rst) |-> $stable(rsp_q))
    else $error("results changed outside done");
  a_fetch_answer: assert property (ftake |=> fetch_valid_q || fetch_blocked_q || fetch_fault_q)
    else $error("fetch not answered next cycle");
  a_fetch_idle: assert property (!ftake |=> !fetch_valid_q)
    else $error("fetch data without a request");
  a_protect_block: assert property (ftake && protect_enable && fetch_origin != 2'h0
    |=> (fetch_blocked_q || fetch_fault_q) && fetch_data_q == 32'h0)
    else $error("protected read not blocked");

  c_status: cover property (take && cmd_req.cmd == 8'h05);
  c_blocked: cover property (fetch_blocked_q);
  c_prog_fail: cover property (cmd_done_q && code == 8'h03);
endmodule : flash_engine_props

bind onchip_flash_command_engine flash_engine_props u_props (
  .clk(clk), .sys_rst(sys_rst), .cmd_valid(cmd_valid), .cmd_req(cmd_req),
  .cpu_env(cpu_env), .protect_enable(protect_enable), .fetch_req(fetch_req),
  .fetch_addr(fetch_addr), .fetch_origin(fetch_origin), .cmd_ready_q(cmd_ready_q),
  .cmd_done_q(cmd_done_q), .rsp_q(rsp_q), .fetch_ready_q(fetch_ready_q),
  .fetch_valid_q(fetch_valid_q), .fetch_blocked_q(fetch_blocked_q),
  .fetch_fault_q(fetch_fault_q), .fetch_data_q(fetch_data_q));

// *** sim/cpu_cmd_model.sv ***
`timescale 1ns/1ps
module cpu_cmd_model (
  input wire logic clk, // clock
  input wire logic cmd_ready_q, // engine idle
  input wire logic cmd_done_q, // completion pulse
  input wire flash_engine_pkg::cmd_rsp_t rsp_q, // results
  output logic cmd_valid, // request
  output flash_engine_pkg::cmd_req_t cmd_req // working registers
);
  initial
  begin
    cmd_valid = 1'h0;
    cmd_req = '0;
  end

  // registers loaded before the request rises, held until the take edge
  task automatic issue(input flash_engine_pkg::cmd_req_t r, input int lim,
    output flash_engine_pkg::cmd_rsp_t rs, output bit hung);
    int n;
    n = 0;
    @(posedge clk);
    #1;
    while (cmd_ready_q !== 1'h1 && n < lim)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    cmd_req = r;
    cmd_valid = 1'h1;
    @(posedge clk);
    #1;
    cmd_valid = 1'h0;
    cmd_req = ~r; // released registers hold garbage, not the last command
    while (cmd_done_q !== 1'h1 && n < lim)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    rs = rsp_q;
    hung = (n >= lim);
  endtask : issue
endmodule : cpu_cmd_model

// *** sim/tb.sv ***
`timescale 1ns/1ps
module tb;
  typedef struct packed {
    logic [7:0] cmd;
    logic [15:0] off;
    logic [15:0] per;
    logic [15:0] sp;
    logic prot;
    logic vpp;
    logic [7:0] exp;
  } row_t;
  logic clk = 1'h0;
  logic sys_rst = 1'h1;
  logic protect_enable = 1'h0;
  logic vpp_present_pin = 1'h1;
  logic fetch_req = 1'h0;
  logic [19:0] fetch_addr = 20'h00000;
  logic [1:0] fetch_origin = 2'h0;
  logic init_phase = 1'h1;
  logic map_segment1 = 1'h0;
  logic cmd_valid, cmd_ready_q, cmd_done_q, fr, fv, fb, ff;
  logic [31:0] fd;
  flash_engine_pkg::cmd_req_t cmd_req;
  flash_engine_pkg::cpu_env_t cpu_env;
  flash_engine_pkg::cmd_rsp_t rsp_q, rs;
  int miscompares = 0;
  int checked = 0;
  bit hung;
  row_t rows [13];

  always #10 clk = ~clk;

  onchip_flash_command_engine #(.MAX_RETRY(1), .ALG_REVISION(16'h0a05),
    .CIRCUIT_ID_LO(16'h1357), .CIRCUIT_ID_HI(16'h2468)) DUT (
    .clk(clk), .sys_rst(sys_rst), .cmd_valid(cmd_valid), .cmd_req(cmd_req),
    .cpu_env(cpu_env), .protect_enable(protect_enable), .vpp_present_pin(vpp_present_pin),
    .init_phase(init_phase), .map_segment1(map_segment1),
    .fetch_req(fetch_req), .fetch_addr(fetch_addr),
    .fetch_origin(fetch_origin), .cmd_ready_q(cmd_ready_q), .cmd_done_q(cmd_done_q),
    .rsp_q(rsp_q), .fetch_ready_q(fr), .fetch_valid_q(fv), .fetch_blocked_q(fb),
    .fetch_fault_q(ff), .fetch_data_q(fd));
  cpu_cmd_model cpu (.clk(clk), .cmd_ready_q(cmd_ready_q), .cmd_done_q(cmd_done_q),
    .rsp_q(rsp_q), .cmd_valid(cmd_valid), .cmd_req(cmd_req));

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e)
    begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic wrap_up();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : wrap_up

  // a hang counts against the run and ends it
  task automatic run(input logic [7:0] c, input logic [15:0] off, lo, hi, cnt, input int lim);
    cpu.issue('{c, 4'h0, off, lo, hi, cnt}, lim, rs, hung);
    if (hung)
    begin
      miscompares++;
      wrap_up();
    end
  endtask : run

  // one fetch; the answer is looked at in its single valid cycle
  task automatic fetch(input logic [19:0] a, input logic [1:0] o);
    fetch_req = 1'h1;
    fetch_addr = a;
    fetch_origin = o;
    @(posedge clk);
    #1;
    fetch_req = 1'h0;
    fetch_addr = ~a;
  endtask : fetch

  initial
  begin
    cpu_env = '{16'h1000, 16'h0000, 16'h0028, 1'h1, 1'h0};
    rows = '{'{8'h05, 16'h0000, 16'h0028, 16'h1000, 1'h0, 1'h1, 8'h00},
      '{8'h77, 16'h0000, 16'h001d, 16'h1000, 1'h0, 1'h1, 8'hff},
      '{8'h01, 16'h0000, 16'h001d, 16'h1000, 1'h0, 1'h1, 8'h05},
      '{8'h01, 16'h0000, 16'h01f5, 16'h1000, 1'h0, 1'h1, 8'h05},
      '{8'h01, 16'h0001, 16'h001e, 16'h1000, 1'h0, 1'h1, 8'h04},
      '{8'h01, 16'h0000, 16'h01f4, 16'h0062, 1'h0, 1'h1, 8'h06},
      '{8'h01, 16'h0001, 16'h0028, 16'h0064, 1'h0, 1'h1, 8'h04},
      '{8'h01, 16'h0000, 16'h001d, 16'h1000, 1'h1, 1'h1, 8'h05},
      '{8'h01, 16'h0000, 16'h0028, 16'h1000, 1'h1, 1'h1, 8'h01},
      '{8'h01, 16'h0000, 16'h0028, 16'h1000, 1'h0, 1'h0, 8'h02},
      '{8'h04, 16'h0000, 16'h0028, 16'h1000, 1'h0, 1'h1, 8'h07},
      '{8'h03, 16'h0100, 16'h0028, 16'h1000, 1'h0, 1'h1, 8'h0a},
      '{8'h01, 16'h8000, 16'h0028, 16'h1000, 1'h0, 1'h1, 8'h04}};
    repeat (2) @(posedge clk);
    #1;
    sys_rst = 1'h0;
    chk("reset result", 32'h0, {15'h0, cmd_done_q, rsp_q.result_word});
    // parameter checks; erase bank number rides in the data word
    foreach (rows[i])
    begin
      cpu_env.cpu_period_ns = rows[i].per;
      cpu_env.stack_pointer = rows[i].sp;
      protect_enable = rows[i].prot;
      vpp_present_pin = rows[i].vpp;
      repeat (4) @(posedge clk); // supply sense passes two sync flops
      run(rows[i].cmd, rows[i].off, {13'h0, rows[i].cmd == 8'h04, 2'h0}, 16'h0, 16'h0, 100);
      chk("row code", {24'h0, rows[i].exp}, {16'h0, rs.result_word});
    end
    run(8'h05, 16'h0, 16'h0, 16'h0, 16'h0, 100);
    chk("revision", 32'h0a05, {16'h0, rs.target_offset_word});
    chk("ids", 32'h24681357, {rs.data_high_word, rs.data_low_word});
    // blank bank 0 first: programming can only clear bits
    run(8'h04, 16'h0, 16'h0, 16'h0, 16'h0, 30000);
    chk("erase", 32'h0, {16'h0, rs.result_word});
    run(8'h01, 16'h0000, 16'h1234, 16'h0, 16'h0, 100);
    chk("single code", 32'h0, {rs.result_word, rs.target_offset_word});
    chk("single data", 32'hffff1234, {rs.data_high_word, rs.data_low_word});
    run(8'h02, 16'h0004, 16'haaaa, 16'h5555, 16'h0, 100);
    chk("double data", 32'h5555aaaa, {rs.data_high_word, rs.data_low_word});
    fetch(20'h00000, 2'h0);
    chk("fetch", 32'hffff1234, fd);
    fetch(20'h00004, 2'h0);
    chk("fetch pair", {31'h0, fv}, 32'h1);
    chk("fetch pair data", 32'h5555aaaa, fd);
    protect_enable = 1'h1;
    fetch(20'h00000, 2'h1);
    chk("blocked", 32'h1, {31'h0, fb});
    chk("blocked data", 32'h0, fd);
    fetch(20'h00000, 2'h0);
    chk("flash code read", 32'hffff1234, fd);
    protect_enable = 1'h0;
    fetch(20'h08000, 2'h0);
    chk("unmapped", 32'h1, {31'h0, ff});
    run(8'h01, 16'h0000, 16'hffff, 16'h0, 16'h0, 100);
    chk("fail code", 32'h00031234, {rs.result_word, rs.data_low_word});
    run(8'h03, 16'h0100, 16'h0000, 16'h0, 16'h0002, 200);
    chk("block", 32'h00000102, {rs.result_word, rs.target_offset_word});
    fetch(20'h00100, 2'h0);
    chk("block data", 32'hffff1234, fd);
    run(8'h03, 16'h0100, 16'h8000, 16'h0, 16'h0001, 100);
    chk("bad source", 32'h0009, {16'h0, rs.result_word});
    cpu_env.pll_locked = 1'h0;
    run(8'h01, 16'h0008, 16'h0000, 16'h0, 16'h0, 100);
    chk("clock loss", 32'h000b, {16'h0, rs.result_word});
    // segment 1 mapping is taken only while initialization is open
    map_segment1 = 1'h1;
    @(posedge clk);
    #1;
    init_phase = 1'h0;
    map_segment1 = 1'h0;
    fetch(20'h10000, 2'h0);
    chk("segment 1", 32'hffff1234, fd);
    wrap_up();
  end
endmodule : tb
